/* ifd_decoder.sv */
`default_nettype none
// Overview of operation
// - each instruction is one 14-bit word: opcode plus operand fields
// - every word falls in exactly one of three classes
// - target bit 0 writes accumulator, 1 writes the file register
// - register address operand spans 0x00 through 0x7F
// - bit operand picks one of eight bits of the register
// - literal operand is 8 bits, jump target 11 bits
// - one instruction cycle is four oscillator periods
// - taken skip or counter change adds a no-operation cycle
// - file-register instructions always read before they write
// - don't-care opcode bits never change the decoded operation
module ifd_decoder
  import ifd_pkg::*;
#(
  parameter int unsigned PHASES = ifd_pkg::IFD_PHASES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // instruction word from program memory
  input wire logic [ifd_pkg::IFD_WORD_W-1:0] instr_word_i,
  // condition result for skip instructions, valid in the last phase
  input wire logic skip_cond_i,
  // fetch side
  output logic [ifd_pkg::IFD_PC_W-1:0] program_counter_o,
  // phase sequencing
  output logic [1:0] phase_o,
  output logic cycle_end_o,
  output logic flush_o,
  // decoded class
  output logic [1:0] instr_class_o,
  // operand fields
  output logic [ifd_pkg::IFD_ADDR_W-1:0] reg_addr_o,
  output logic [ifd_pkg::IFD_BIT_W-1:0] bit_sel_o,
  output logic [ifd_pkg::IFD_LIT8_W-1:0] lit8_o,
  output logic [ifd_pkg::IFD_LIT11_W-1:0] lit11_o,
  // data path steering
  output logic reg_read_o,
  output logic reg_write_o,
  output logic acc_write_o
);
  import ifd_pkg::*;

  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  logic flush_r;
  logic flush_nxt;
  logic [IFD_PC_W-1:0] pc_r;
  logic [IFD_PC_W-1:0] pc_nxt;
  logic [IFD_WORD_W-1:0] ir_r;
  logic [1:0] cls_r;
  logic [IFD_ADDR_W-1:0] addr_r;
  logic [IFD_BIT_W-1:0] bsel_r;
  logic [IFD_LIT8_W-1:0] lit8_r;
  logic [IFD_LIT11_W-1:0] lit11_r;
  logic rd_r;
  logic wr_r;
  logic acc_r;
  logic end_r;

  // field split of the latched word
  wire [1:0] grp = ir_r[IFD_GRP_MSB:IFD_GRP_LSB];
  wire [3:0] byte_op = ir_r[11:8];
  wire [1:0] bit_op = ir_r[IFD_BITOP_MSB:IFD_BITOP_LSB];
  wire dest = ir_r[IFD_DEST_POS];
  wire [IFD_ADDR_W-1:0] faddr = ir_r[IFD_ADDR_W-1:0];
  wire [IFD_BIT_W-1:0] fbit =
    ir_r[IFD_BITSEL_LSB+2:IFD_BITSEL_LSB];
  wire [IFD_LIT8_W-1:0] k8 = ir_r[IFD_LIT8_W-1:0];
  wire [IFD_LIT11_W-1:0] k11 = ir_r[IFD_LIT11_W-1:0];
  wire [1:0] lit_op = ir_r[IFD_SEL_POS:IFD_SEL_POS-1];

  // classes are mutually exclusive by the top two bits
  wire is_byte = (grp == IFD_GRP_BYTE);
  wire is_bit = (grp == IFD_GRP_BIT);
  wire is_ctl = (grp == IFD_GRP_JUMP) || (grp == IFD_GRP_LIT);
  wire [1:0] cls = is_byte ? 2'(IFD_CLS_BYTE) :
                   is_bit ? 2'(IFD_CLS_BIT) : 2'(IFD_CLS_LIT);

  // misc space (op 0 with d=0) holds no-op and control words, not a file
  // access; x bits in those words are ignored by matching only fixed bits
  wire misc = is_byte && (byte_op == IFD_OP_MISC) && !dest;
  wire clrw = is_byte && (byte_op == IFD_OP_CLR) && !dest;
  wire file_op = (is_byte && !misc && !clrw) || is_bit;
  wire ret_op = misc && (ir_r[6:0] == IFD_CTL_RETURN ||
                         ir_r[6:0] == IFD_CTL_RETFIE);
  wire retlit = (grp == IFD_GRP_LIT) && (lit_op == IFD_LOP_RETLIT);
  wire jump = (grp == IFD_GRP_JUMP);
  wire skip_op = (is_byte && (byte_op == IFD_OP_DECSZ ||
                              byte_op == IFD_OP_INCSZ)) ||
                 (is_bit && (bit_op == IFD_BOP_TST_CLR ||
                             bit_op == IFD_BOP_TST_SET));
  // counter change or true test forces the extra cycle
  wire pc_change = jump || ret_op || retlit;
  wire need_flush = !flush_r && (pc_change || (skip_op && skip_cond_i));

  // writes: bit sets/clears go to the file; byte ops follow d
  wire bit_wr = is_bit && !bit_op[1];
  wire byte_wr = is_byte && !misc && !clrw && dest && !skip_op;
  wire skip_wr = is_byte && skip_op && dest;
  wire f_write = bit_wr || byte_wr || skip_wr;
  wire a_write = (is_byte && !misc && !dest) ||
                 ((grp == IFD_GRP_LIT));

  // phase counter wraps every four periods
  wire last_ph = (phase_r == 2'(PHASES - 1));
  assign phase_nxt = last_ph ? IFD_PH_RESET : phase_r + 2'h1;

  // a flushed slot is a no-operation; the flush ends after one cycle
  assign flush_nxt = last_ph ? need_flush : flush_r;
  // jump targets load the 11-bit field with the top two counter bits cleared; returns leave the stack to the core,
  // so this block only advances past them and signals the flush
  assign pc_nxt = !last_ph ? pc_r :
                  (jump && !flush_r) ? {2'h0, k11} :
                  pc_r + 13'h0001;

  // phase and counter state
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_r <= IFD_PH_RESET;
      flush_r <= 1'b1;
      pc_r <= IFD_PC_RESET;
    end else begin
      phase_r <= phase_nxt;
      flush_r <= flush_nxt;
      pc_r <= pc_nxt;
    end
  end

  // fetch latch: the next word is taken at the end of each cycle
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ir_r <= IFD_NOP_WORD;
    end else if (last_ph) begin
      ir_r <= instr_word_i;
    end
  end

  // decoded outputs registered every period; read and write strobes suppressed while flushing, fields are not
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cls_r <= 2'(IFD_CLS_BYTE);
      addr_r <= 7'h00;
      bsel_r <= 3'h0;
      lit8_r <= 8'h00;
      lit11_r <= 11'h000;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      acc_r <= 1'b0;
      end_r <= 1'b0;
    end else begin
      cls_r <= cls;
      addr_r <= faddr;
      bsel_r <= fbit;
      lit8_r <= k8;
      lit11_r <= k11;
      rd_r <= file_op && !flush_r;
      wr_r <= f_write && !flush_r && last_ph;
      acc_r <= (a_write || clrw) && !flush_r && last_ph;
      end_r <= last_ph;
    end
  end

  // output drive
  assign program_counter_o = pc_r;
  assign phase_o = phase_r;
  assign cycle_end_o = end_r;
  assign flush_o = flush_r;
  assign instr_class_o = cls_r;
  assign reg_addr_o = addr_r;
  assign bit_sel_o = bsel_r;
  assign lit8_o = lit8_r;
  assign lit11_o = lit11_r;
  assign reg_read_o = rd_r;
  assign reg_write_o = wr_r;
  assign acc_write_o = acc_r;
endmodule
`default_nettype wire

/* ifd_decoder_monitor.sv */
`default_nettype none
module ifd_decoder_chk (
  // clock, reset and word
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [13:0] instr_word_i,
  // decoder outputs
  input wire logic [1:0] phase_o,
  input wire logic cycle_end_o,
  input wire logic flush_o,
  input wire logic [1:0] instr_class_o,
  input wire logic [6:0] reg_addr_o,
  input wire logic [2:0] bit_sel_o,
  input wire logic [7:0] lit8_o,
  input wire logic [10:0] lit11_o,
  input wire logic reg_read_o,
  input wire logic reg_write_o,
  input wire logic acc_write_o
);
  logic [13:0] word_r;
  logic [13:0] done_r;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // word taken at phase 3 and the one before it; a cycle end shows the
  // fields, read and writes of the word that has just finished
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      word_r <= 14'h0000;
      done_r <= 14'h0000;
    end else if (phase_o == 2'h3) begin
      word_r <= instr_word_i;
      done_r <= word_r;
    end
  end
  property p_cycle; cycle_end_o |-> phase_o == 2'h0 ##1 phase_o == 2'h1
    ##1 phase_o == 2'h2 ##1 phase_o == 2'h3 ##1 cycle_end_o; endproperty
  property p_addr; cycle_end_o |-> reg_addr_o == done_r[6:0]; endproperty
  property p_class; cycle_end_o |-> instr_class_o ==
    (done_r[13] ? 2'h2 : {1'b0, done_r[12]}); endproperty
  property p_field; cycle_end_o |-> bit_sel_o == done_r[9:7] &&
    lit8_o == done_r[7:0] && lit11_o == done_r[10:0]; endproperty
  property p_dfile; cycle_end_o && reg_read_o && instr_class_o == 2'h0 &&
    lit8_o[7] |-> reg_write_o && !acc_write_o; endproperty
  property p_dacc; cycle_end_o && reg_read_o && instr_class_o == 2'h0 &&
    !lit8_o[7] |-> acc_write_o && !reg_write_o; endproperty
  property p_read; phase_o == 2'h1 && !flush_o && (instr_class_o == 2'h1 ||
    instr_class_o == 2'h0 && lit8_o[7]) |-> reg_read_o [*4]; endproperty
  property p_flush; phase_o == 2'h1 && flush_o |-> !reg_read_o
    ##3 !reg_write_o && !acc_write_o; endproperty
  a_cycle:
    assert property (p_cycle) else $error("phase order wrong");
  a_addr:
    assert property (p_addr) else $error("address field wrong");
  a_class:
    assert property (p_class) else $error("class wrong");
  a_field:
    assert property (p_field) else $error("operand field wrong");
  a_dfile:
    assert property (p_dfile) else $error("file write missing");
  a_dacc:
    assert property (p_dacc) else $error("accumulator write missing");
  a_read:
    assert property (p_read) else $error("file read missing");
  a_flush:
    assert property (p_flush) else $error("flushed word had effect");
  c_flush: cover property (cycle_end_o && flush_o);
  c_file: cover property (reg_write_o);
  c_acc: cover property (acc_write_o);
endmodule
bind ifd_decoder ifd_decoder_chk i_chk (.*);
`default_nettype wire

/* ifd_pkg.sv */
`default_nettype none
package ifd_pkg;
  // word and field geometry
  localparam int unsigned IFD_WORD_W = 14;
  localparam int unsigned IFD_ADDR_W = 7;
  localparam int unsigned IFD_BIT_W = 3;
  localparam int unsigned IFD_LIT8_W = 8;
  localparam int unsigned IFD_LIT11_W = 11;
  localparam int unsigned IFD_PC_W = 13;
  localparam int unsigned IFD_DEST_POS = 7;
  localparam int unsigned IFD_BITSEL_LSB = 7;
  localparam int unsigned IFD_GRP_MSB = 13;
  localparam int unsigned IFD_GRP_LSB = 12;
  localparam int unsigned IFD_BITOP_MSB = 11;
  localparam int unsigned IFD_BITOP_LSB = 10;
  localparam int unsigned IFD_SEL_POS = 11;
  // group codes in the top two bits
  localparam logic [1:0] IFD_GRP_BYTE = 2'h0;
  localparam logic [1:0] IFD_GRP_BIT = 2'h1;
  localparam logic [1:0] IFD_GRP_JUMP = 2'h2;
  localparam logic [1:0] IFD_GRP_LIT = 2'h3;
  // byte group sub codes
  localparam logic [3:0] IFD_OP_MISC = 4'h0;
  localparam logic [3:0] IFD_OP_CLR = 4'h1;
  localparam logic [3:0] IFD_OP_DECSZ = 4'hB;
  localparam logic [3:0] IFD_OP_INCSZ = 4'hF;
  // bit group sub codes
  localparam logic [1:0] IFD_BOP_TST_CLR = 2'h2;
  localparam logic [1:0] IFD_BOP_TST_SET = 2'h3;
  // whole-word control codes in the misc space
  localparam logic [6:0] IFD_CTL_RETURN = 7'h08;
  localparam logic [6:0] IFD_CTL_RETFIE = 7'h09;
  // literal group: return-with-literal sub code
  localparam logic [1:0] IFD_LOP_RETLIT = 2'h1;
  // four oscillator periods per instruction cycle
  localparam int unsigned IFD_PHASES = 4;
  localparam logic [1:0] IFD_PH_LAST = 2'h3;
  localparam logic [1:0] IFD_PH_RESET = 2'h0;
  localparam logic [IFD_PC_W-1:0] IFD_PC_RESET = 13'h0000;
  localparam logic [IFD_WORD_W-1:0] IFD_NOP_WORD = 14'h0000;
  // instruction classes
  typedef enum logic [1:0] {
    IFD_CLS_BYTE,
    IFD_CLS_BIT,
    IFD_CLS_LIT
  } ifd_class_type;
endpackage
`default_nettype wire

/* ifd_prog_mem.sv */
`default_nettype none
module ifd_prog_mem (
  // fetch side
  input wire logic [12:0] pc_i,
  output logic [13:0] word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // only 64 words, the address wraps: enough for the bench programme
  logic [13:0] mem [0:63];
  assign word_o = mem[pc_i[5:0]];
endmodule
`default_nettype wire

/* test_instruction_format_decoder.sv */
`default_nettype none
module test_instruction_format_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [13:0] w; logic f;} ifd_note_type;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, skip_cond_i = 1'b0;
  logic [12:0] pc;
  logic [13:0] word;
  logic [1:0] ph, cls;
  logic ce, fl, rd, wf, wa;
  logic [6:0] ad;
  logic [2:0] bs;
  logic [7:0] l8;
  logic [10:0] l11;
  logic [15:0] lfsr = 16'h0010;
  ifd_note_type q[$];
  ifd_note_type cur, prv = '{w: 14'h0000, f: 1'b1};
  int n_errors = 0, samples_checked = 0, cyc = 0;
  ifd_decoder i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .instr_word_i(word), .skip_cond_i(skip_cond_i), .program_counter_o(pc),
    .phase_o(ph), .cycle_end_o(ce), .flush_o(fl), .instr_class_o(cls),
    .reg_addr_o(ad), .bit_sel_o(bs), .lit8_o(l8), .lit11_o(l11),
    .reg_read_o(rd), .reg_write_o(wf), .acc_write_o(wa));
  ifd_prog_mem i_mem (.pc_i(pc), .word_o(word));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  function automatic logic [15:0] step(logic [15:0] r);
    return {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
  endfunction
  // random words avoid jumps, returns and skips; one jump and one skip are placed by hand
  function automatic logic [13:0] gen(logic [15:0] r);
    if (r[15:14] == 2'h0) return {2'h0, 4'h2 + {1'b0, r[10:8]}, r[7:0]};
    if (r[15:14] == 2'h1) return {2'h1, 1'b0, r[10:0]};
    return {2'h3, (r[11:10] == 2'h1) ? 2'h0 : r[11:10], r[9:0]};
  endfunction
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // skip test random, forced true while the skip word runs; hang guard
  always @(posedge sys_clk_i) begin
    lfsr <= step(lfsr);
    skip_cond_i <= (pc == 13'h0021) | lfsr[0];
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_errors++;
      summarize();
    end
  end
  // program: random words, a jump at 0x14, a taken skip at 0x20
  initial begin
    logic [15:0] r;
    r = 16'h0010;
    for (int i = 0; i < 64; i++) begin
      r = step(r);
      i_mem.mem[i] = gen(r);
    end
    i_mem.mem[20] = 14'h2820;
    i_mem.mem[32] = 14'h0BFF;
    for (int i = 0; i < 48; i++)
      if (i < 22 || i > 31)
        q.push_back('{w: i_mem.mem[i], f: i == 21 || i == 33});
    repeat (10) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    while (q.size() != 0) @(posedge sys_clk_i);
    repeat (4) @(posedge sys_clk_i);
    $display("test program done");
    summarize();
  end
  // a cycle end shows the new word's flush and the finished word's fields,
  // read and writes
  always @(posedge sys_clk_i) begin
    #1;
    if (ce === 1'b1 && q.size() != 0) begin
      cur = q.pop_front();
      chk("flush", fl, cur.f);
      chk("read", rd, !prv.f && !prv.w[13]);
      chk("fwrite", wf, !prv.f && (prv.w[13:12] == 2'h0 ?
        prv.w[7] : prv.w[13:12] == 2'h1));
      chk("awrite", wa, !prv.f && (prv.w[13:12] == 2'h0 ?
        !prv.w[7] : prv.w[13:12] == 2'h3));
      if (prv.w == 14'h2820)
        chk("pc", pc, prv.w[10:0]);
      begin
        chk("class", cls, prv.w[13] ? 2'h2 : {1'b0, prv.w[12]});
        chk("addr", ad, prv.w[6:0]);
        chk("bit", bs, prv.w[9:7]);
        chk("lit8", l8, prv.w[7:0]);
        chk("lit11", l11, prv.w[10:0]);
      end
      prv = cur;
    end
  end
endmodule
`default_nettype wire
